/* File: hw/rsp_pin_filter.sv */
`timescale 1ns/1ps
`include "rsp_regs.svh"

module rsp_pin_filter
  import rsp_pkg::*;
#(
  parameter int MIN_CYC = `RSP_PIN_MIN_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pinN,
  output logic hit
);

  logic [15:0] lowCnt_r;
  logic hit_r;
  wire reached = (lowCnt_r >= 16'(MIN_CYC));

  // pulses shorter than the minimum never reach the count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_r <= 16'h0000;
      hit_r <= 1'b0;
    end else if (pinN) begin
      lowCnt_r <= 16'h0000;
      hit_r <= 1'b0;
    end else begin
      if (!reached) lowCnt_r <= lowCnt_r + 16'h0001;
      hit_r <= reached;
    end
  end

  assign hit = hit_r;

endmodule : rsp_pin_filter

/* File: hw/rsp_reset_sleep.sv */
// Operation
// - reset loads registers, then fetch at vector
// - any source resets ports without clock
// - fuse-selected delay stretches reset after release
// - five sources, any one asserts reset
// - reset pin counts only beyond minimum width
// - watchdog reset needs enable and timeout
// - brown-out reset needs enable and low supply
// - scan reset register one holds reset
// - low supply holds reset; rise starts delay
// - supply fall reasserts reset without delay
// - enabled converter stays on while sleeping
// - converter re-enable makes next conversion extended
// - comparator off in deep sleep modes
// - reference on only when someone needs it
// - fused brown-out detector stays on sleeping
// - enabled watchdog keeps running while sleeping
// - deep sleep disables input buffers except wake
// - input disable bits turn buffers off always
// - debug fuse with scan port enabled keeps main clock in power-down and power-save
// - test data out undriven unless shifting
// - watchdog gives one-cycle pulse, delay follows
// - cause flags set, power-on clears, write zero
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rsp_regs.svh"

module rsp_reset_sleep
  import rsp_pkg::*;
#(
  parameter int TOUT_UNIT = `RSP_TOUT_UNIT_CYC,
  parameter int PIN_MIN_CYC = `RSP_PIN_MIN_CYC,
  parameter logic [15:0] WAKE_PINS = 16'h0001
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic supplyAbovePot,
  input wire logic resetPinN,
  input wire logic wdtEnable,
  input wire logic wdtTimeout,
  input wire logic bodBelowThr,
  input wire logic [2:0] brownoutLevelFuses,
  input wire logic [1:0] startupTimeFuses,
  input wire logic [3:0] clockSelectFuses,
  input wire logic debugEnableFuse,
  input wire logic scanPortEnableFuse,
  input wire logic sleepActive,
  input wire logic scanRstShift,
  input wire logic scanTdi,
  input wire logic tapShifting,
  input wire logic tapTdo,
  input wire logic adcConvStart,
  output logic ioRstN,
  output logic cpuRstN,
  output logic fetchVector,
  output logic adcPowerOn,
  output logic adcExtConv,
  output logic acPowerOn,
  output logic refPowerOn,
  output logic bodPowerOn,
  output logic wdtRunOn,
  output logic mainClkOn,
  output logic [15:0] inputBufEn,
  output logic scanPortOn,
  output logic tdoOut,
  output logic tdoOeN
);

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  logic extHit;
  logic wdtPulse_r;
  logic scanRstReg_r;
  logic [7:0] ctrl_r;
  rsp_src_t src;

  rsp_pin_filter #(
    .MIN_CYC(PIN_MIN_CYC)
  ) uPinFilter (
    .clk(clk),
    .resetn(resetn),
    .pinN(resetPinN),
    .hit(extHit)
  );

  wire bodEnabled = (brownoutLevelFuses != `RSP_BOD_OFF);
  wire scanEnabled = scanPortEnableFuse & ~ctrl_r[`RSP_CTRL_SCANDIS];

  assign src.por = ~supplyAbovePot;
  assign src.ext = extHit;
  assign src.brownout_detector = bodEnabled & bodBelowThr;
  assign src.wdt = wdtPulse_r;
  assign src.scan = scanRstReg_r;

  // any of the five pulls the async reset net low at once
  wire anySrc = |src;
  wire srcN = resetn & ~anySrc;

  // one cycle wide, repeating every other cycle while the timeout input stays high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wdtPulse_r <= 1'b0;
    else wdtPulse_r <= wdtEnable & wdtTimeout & ~wdtPulse_r;
  end

  // scan reset register survives internal reset, it is a source itself
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) scanRstReg_r <= 1'b0;
    else if (scanEnabled && scanRstShift) scanRstReg_r <= scanTdi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay counter

  logic [23:0] toutCnt_r;
  logic ioRstN_r;
  logic cpuRstN_r;
  logic fetch_r;

  wire [23:0] toutBase = 24'(TOUT_UNIT) * (24'(startupTimeFuses) + 24'h000001);
  wire [23:0] toutTarget = toutBase << clockSelectFuses[1:0];
  wire stretchDone = (toutCnt_r >= toutTarget);

  // counting starts only after the last source drops, e.g. after the
  // watchdog pulse falls
  always_ff @(posedge clk or negedge srcN) begin
    if (!srcN) toutCnt_r <= 24'h000000;
    else if (!stretchDone) toutCnt_r <= toutCnt_r + 24'h000001;
  end

  always_ff @(posedge clk or negedge srcN) begin
    if (!srcN) begin
      ioRstN_r <= 1'b0;
      cpuRstN_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      ioRstN_r <= stretchDone;
      cpuRstN_r <= ioRstN_r;
      fetch_r <= ioRstN_r & ~cpuRstN_r;
    end
  end

  assign ioRstN = ioRstN_r;
  assign cpuRstN = cpuRstN_r;
  assign fetchVector = fetch_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  rsp_aphase_t ap_r;
  logic [31:0] rdata_r;
  logic hreadyout_r;
  logic [7:0] pwr_r;
  logic [7:0] digital_input_disable_0_r;
  logic [7:0] digital_input_disable_1_r;
  logic [4:0] flags_r;
  logic [7:0] status;

  wire addrPhase = hsel & htrans[1] & hready;
  wire [2:0] aIdx = haddr[4:2];
  wire inMap = (haddr[31:5] == 27'h0) && (aIdx <= `RSP_OFS_STATUS >> 2);
  wire wrPhase = ap_r.valid & ap_r.write;
  wire wrCtrl = wrPhase && (ap_r.idx == 3'(`RSP_OFS_CTRL >> 2));
  wire wrFlags = wrPhase && (ap_r.idx == 3'(`RSP_OFS_FLAGS >> 2));
  wire wrPwr = wrPhase && (ap_r.idx == 3'(`RSP_OFS_PWR >> 2));
  wire wrDidr0 = wrPhase && (ap_r.idx == 3'(`RSP_OFS_DIGITAL_INPUT_DISABLE_0 >> 2));
  wire wrDidr1 = wrPhase && (ap_r.idx == 3'(`RSP_OFS_DIGITAL_INPUT_DISABLE_1 >> 2));

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    if (inMap) begin
      unique case (aIdx)
        3'(`RSP_OFS_CTRL >> 2): rdMux = {24'h000000, ctrl_r};
        3'(`RSP_OFS_FLAGS >> 2): rdMux = {27'h0000000, flags_r};
        3'(`RSP_OFS_PWR >> 2): rdMux = {24'h000000, pwr_r};
        3'(`RSP_OFS_DIGITAL_INPUT_DISABLE_0 >> 2): rdMux = {24'h000000, digital_input_disable_0_r};
        3'(`RSP_OFS_DIGITAL_INPUT_DISABLE_1 >> 2): rdMux = {24'h000000, digital_input_disable_1_r};
        3'(`RSP_OFS_STATUS >> 2): rdMux = {24'h000000, status};
        default: rdMux = 32'h00000000;
      endcase
    end
  end

  // zero wait states: read data is sampled in the address phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ap_r <= '0;
      rdata_r <= 32'h00000000;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      if (hready) ap_r <= '{valid: addrPhase & inMap, write: hwrite, idx: aIdx};
      if (addrPhase && !hwrite) rdata_r <= rdMux;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // control registers return to reset values while internal reset holds
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `RSP_CTRL_RST;
      pwr_r <= `RSP_PWR_RST;
      digital_input_disable_0_r <= `RSP_DIDR_RST;
      digital_input_disable_1_r <= `RSP_DIDR_RST;
    end else if (!ioRstN_r) begin
      ctrl_r <= `RSP_CTRL_RST;
      pwr_r <= `RSP_PWR_RST;
      digital_input_disable_0_r <= `RSP_DIDR_RST;
      digital_input_disable_1_r <= `RSP_DIDR_RST;
    end else begin
      if (wrCtrl) ctrl_r <= hwdata[7:0];
      if (wrPwr) pwr_r <= hwdata[7:0];
      if (wrDidr0) digital_input_disable_0_r <= hwdata[7:0];
      if (wrDidr1) digital_input_disable_1_r <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags, kept through internal reset

  wire [4:0] setMask = {src.scan, src.wdt, src.brownout_detector, src.ext, src.por};
  wire [4:0] keepMask = wrFlags ? hwdata[4:0] : 5'h1F;
  wire [4:0] flagsNxt = (flags_r & keepMask) | setMask; // set wins over clear

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) flags_r <= `RSP_FLAGS_RST;
    else if (src.por) flags_r <= 5'h01;
    else flags_r <= flagsNxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep power gating

  rsp_sleep_t mode;
  always_comb begin
    unique case (pwr_r[`RSP_PWR_SM_LSB +: 3])
      `RSP_SM_IDLE: mode = RSP_IDLE;
      `RSP_SM_ADCNR: mode = RSP_ADCNR;
      `RSP_SM_PDOWN: mode = RSP_PDOWN;
      `RSP_SM_PSAVE: mode = RSP_PSAVE;
      `RSP_SM_STANDBY: mode = RSP_STANDBY;
      default: mode = RSP_RSVD;
    endcase
  end

  wire adcEn = pwr_r[`RSP_PWR_ADCEN];
  wire acOn = ~pwr_r[`RSP_PWR_ACOFF];
  wire acUsesRef = acOn & pwr_r[`RSP_PWR_ACREF];
  wire lightSleep = (mode == RSP_IDLE) || (mode == RSP_ADCNR);
  wire pdOrPs = (mode == RSP_PDOWN) || (mode == RSP_PSAVE);
  // io and converter clocks both stopped in every mode but the light ones
  wire deepSleep = sleepActive & ~lightSleep;
  wire debugHold = debugEnableFuse & scanEnabled;

  wire adcOnNxt = adcEn;
  // comparator left alone in the light modes, forced off otherwise
  wire acOnNxt = acOn & (~sleepActive | lightSleep);
  // a comparator tied to the reference keeps it on even while sleeping
  wire refNxt = bodEnabled | acUsesRef | adcEn;
  wire clkNxt = ~sleepActive | lightSleep | (mode == RSP_STANDBY) | (pdOrPs & debugHold);

  wire [15:0] didr = {digital_input_disable_1_r, digital_input_disable_0_r};
  logic [15:0] bufNxt;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : gBuf
      assign bufNxt[gi] = ~didr[gi] & ~(deepSleep & ~WAKE_PINS[gi]);
    end
  endgenerate

  logic adcPowerOn_r;
  logic adcExt_r;
  logic acPowerOn_r;
  logic refPowerOn_r;
  logic bodPowerOn_r;
  logic wdtRunOn_r;
  logic mainClkOn_r;
  logic [15:0] inputBufEn_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adcPowerOn_r <= 1'b0;
      acPowerOn_r <= 1'b0;
      refPowerOn_r <= 1'b0;
      bodPowerOn_r <= 1'b0;
      wdtRunOn_r <= 1'b0;
      mainClkOn_r <= 1'b1;
      inputBufEn_r <= 16'h0000;
    end else begin
      adcPowerOn_r <= adcOnNxt;
      acPowerOn_r <= acOnNxt;
      refPowerOn_r <= refNxt;
      bodPowerOn_r <= bodEnabled;
      wdtRunOn_r <= wdtEnable;
      mainClkOn_r <= clkNxt;
      inputBufEn_r <= bufNxt;
    end
  end

  // a fresh power-up sets the flag; the first start then consumes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) adcExt_r <= 1'b0;
    else if (adcOnNxt && !adcPowerOn_r) adcExt_r <= 1'b1;
    else if (adcConvStart || !adcOnNxt) adcExt_r <= 1'b0;
  end

  assign adcPowerOn = adcPowerOn_r;
  assign adcExtConv = adcExt_r;
  assign acPowerOn = acPowerOn_r;
  assign refPowerOn = refPowerOn_r;
  assign bodPowerOn = bodPowerOn_r;
  assign wdtRunOn = wdtRunOn_r;
  assign mainClkOn = mainClkOn_r;
  assign inputBufEn = inputBufEn_r;

  ////////////////////////////////////////////////////////////////////////////
  // scan port pins

  logic scanOn_r;
  logic tdo_r;
  logic tdoOeN_r;

  // pin floats when not shifting; board pull-up must hold it high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scanOn_r <= 1'b0;
      tdo_r <= 1'b0;
      tdoOeN_r <= 1'b1;
    end else begin
      scanOn_r <= scanEnabled;
      tdo_r <= tapTdo;
      tdoOeN_r <= ~(scanEnabled & tapShifting);
    end
  end

  assign scanPortOn = scanOn_r;
  assign tdoOut = tdo_r;
  assign tdoOeN = tdoOeN_r;

  assign status = {2'b00, mainClkOn_r, refPowerOn_r, scanOn_r, bodEnabled, ~stretchDone, ~ioRstN_r};

endmodule : rsp_reset_sleep

/* File: include/rsp_pkg.sv */
package rsp_pkg;

  typedef enum logic [2:0] {
    RSP_IDLE,
    RSP_ADCNR,
    RSP_PDOWN,
    RSP_PSAVE,
    RSP_STANDBY,
    RSP_RSVD
  } rsp_sleep_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] idx;
  } rsp_aphase_t;

  typedef struct packed {
    logic por;
    logic ext;
    logic brownout_detector;
    logic wdt;
    logic scan;
  } rsp_src_t;

endpackage : rsp_pkg

/* File: include/rsp_regs.svh */
`ifndef RSP_REGS_SVH
`define RSP_REGS_SVH

// register byte offsets
`define RSP_OFS_CTRL 5'h00
`define RSP_OFS_FLAGS 5'h04
`define RSP_OFS_PWR 5'h08
`define RSP_OFS_DIGITAL_INPUT_DISABLE_0 5'h0C
`define RSP_OFS_DIGITAL_INPUT_DISABLE_1 5'h10
`define RSP_OFS_STATUS 5'h14

// field positions
`define RSP_CTRL_SCANDIS 0
`define RSP_PWR_ADCEN 0
`define RSP_PWR_ACOFF 1
`define RSP_PWR_ACREF 2
`define RSP_PWR_SM_LSB 4
`define RSP_FLG_POR 0
`define RSP_FLG_EXT 1
`define RSP_FLG_BOD 2
`define RSP_FLG_WDT 3
`define RSP_FLG_SCAN 4

// reset values
`define RSP_CTRL_RST 8'h00
`define RSP_PWR_RST 8'h00
`define RSP_DIDR_RST 8'h00
`define RSP_FLAGS_RST 5'h01

// sleep mode codes of the mode field
`define RSP_SM_IDLE 3'h0
`define RSP_SM_ADCNR 3'h1
`define RSP_SM_PDOWN 3'h2
`define RSP_SM_PSAVE 3'h3
`define RSP_SM_STANDBY 3'h6

// brown-out level code meaning disabled
`define RSP_BOD_OFF 3'h7

// timing
`define RSP_CLK_NS 25
`define RSP_PIN_MIN_NS 2500
`define RSP_PIN_MIN_CYC ((`RSP_PIN_MIN_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`define RSP_TOUT_UNIT_CYC 1024

`endif

/* File: test/rsp_far_side.sv */
`timescale 1ns/1ps
module rsp_far_side (
  input wire logic porLow,
  input wire logic pinLow,
  input wire logic bodLow,
  input wire logic tdoOut,
  input wire logic tdoOeN,
  output logic supplyAbovePot,
  output logic resetPinN,
  output logic bodBelowThr,
  output logic tdoWire
);
  // plain levels, detector hysteresis not modelled
  assign supplyAbovePot = ~porLow;
  assign resetPinN = ~pinLow;
  assign bodBelowThr = bodLow;
  // board pull-up owns the line once released
  assign tdoWire = tdoOeN ? 1'b1 : tdoOut;
endmodule : rsp_far_side

/* File: test/rsp_reset_sleep_sva.sv */
`timescale 1ns/1ps
module rsp_reset_sleep_sva #(
  parameter int PIN_MIN_CYC = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic supplyAbovePot,
  input wire logic resetPinN,
  input wire logic wdtEnable,
  input wire logic wdtTimeout,
  input wire logic bodBelowThr,
  input wire logic [2:0] brownoutLevelFuses,
  input wire logic scanPortEnableFuse,
  input wire logic tapShifting,
  input wire logic ioRstN,
  input wire logic cpuRstN,
  input wire logic fetchVector,
  input wire logic bodPowerOn,
  input wire logic refPowerOn,
  input wire logic wdtRunOn,
  input wire logic scanPortOn,
  input wire logic tdoOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // saturating so a stuck pin never wraps to a short count
  logic [7:0] lowCnt_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lowCnt_r <= 8'h00;
    else if (resetPinN) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hFF) lowCnt_r <= lowCnt_r + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  chk_wdt_pulse: assert property (ioRstN && wdtEnable && wdtTimeout |=> !ioRstN)
    else $error("watchdog expiry missed");
  chk_por_hold: assert property (!supplyAbovePot |-> !ioRstN && !cpuRstN)
    else $error("low supply not in reset");
  chk_bod_reset: assert property (bodBelowThr && brownoutLevelFuses != 3'h7 |-> !ioRstN)
    else $error("brown-out not in reset");
  chk_pin_long: assert property (lowCnt_r > PIN_MIN_CYC + 2 |-> !ioRstN)
    else $error("long pin pulse ignored");
  chk_vector_pulse: assert property ($rose(cpuRstN) |-> fetchVector && ioRstN ##1 !fetchVector)
    else $error("vector pulse wrong");
  chk_stretch_min: assert property ($rose(ioRstN) |-> !$past(ioRstN, 4) && !cpuRstN)
    else $error("reset released too early");
  chk_bod_alive: assert property (brownoutLevelFuses != 3'h7 |=> bodPowerOn && refPowerOn)
    else $error("detector or reference off");
  chk_wdt_alive: assert property (wdtEnable |=> wdtRunOn)
    else $error("watchdog stopped");
  chk_scan_off: assert property (!scanPortEnableFuse |=> !scanPortOn && tdoOeN)
    else $error("scan port on without fuse");
  chk_tdo_float: assert property (!tapShifting |=> tdoOeN)
    else $error("data out driven while idle");
  cov_release: cover property ($rose(ioRstN));
  cov_vector: cover property (fetchVector);
  cov_tdo: cover property (!tdoOeN);
endmodule : rsp_reset_sleep_sva

bind rsp_reset_sleep rsp_reset_sleep_sva #(.PIN_MIN_CYC(PIN_MIN_CYC)) u_sva (
  .clk, .resetn, .supplyAbovePot, .resetPinN, .wdtEnable, .wdtTimeout, .bodBelowThr,
  .brownoutLevelFuses, .scanPortEnableFuse, .tapShifting, .ioRstN, .cpuRstN, .fetchVector,
  .bodPowerOn, .refPowerOn, .wdtRunOn, .scanPortOn, .tdoOeN);

/* File: test/rsp_reset_sleep_tb.sv */
`timescale 1ns/1ps
`include "rsp_regs.svh"
module rsp_reset_sleep_tb;
  import rsp_pkg::*;
  localparam int UNIT = 4;
  localparam int SRC[7] = '{0, 0, 1, 1, 2, 2, 3};
  localparam int LEN[7] = '{2, 8, 1, 1, 2, 2, 20};
  localparam logic [4:0] FLG[7] = '{5'h00, 5'h02, 5'h00, 5'h08, 5'h00, 5'h04, 5'h10};
  localparam logic [2:0] MODES[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, startupTimeFuses = 2'h0;
  logic [3:0] clockSelectFuses = 4'h0;
  logic [2:0] brownoutLevelFuses = 3'h7;
  logic porLow = 1'b1, pinLow = 1'b0, bodLow = 1'b0, wdtEnable = 1'b0, wdtTimeout = 1'b0;
  logic debugEnableFuse = 1'b0, scanPortEnableFuse = 1'b0, sleepActive = 1'b0, adcConvStart = 1'b0;
  logic scanRstShift = 1'b0, scanTdi = 1'b0, tapShifting = 1'b0, tapTdo = 1'b0;
  logic hreadyout, hresp, supplyAbovePot, resetPinN, bodBelowThr, tdoWire, ioRstN, cpuRstN, fetchVector;
  logic adcPowerOn, adcExtConv, acPowerOn, refPowerOn, bodPowerOn, wdtRunOn, mainClkOn;
  logic scanPortOn, tdoOut, tdoOeN;
  logic [15:0] inputBufEn;
  int miscompares = 0, check_count = 0, cyc = 0;

  always #12.5 clk = ~clk;

  rsp_reset_sleep #(.TOUT_UNIT(UNIT), .PIN_MIN_CYC(3)) u_dut (
    .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .supplyAbovePot, .resetPinN, .wdtEnable, .wdtTimeout,
    .bodBelowThr, .brownoutLevelFuses, .startupTimeFuses, .clockSelectFuses, .debugEnableFuse,
    .scanPortEnableFuse, .sleepActive, .scanRstShift, .scanTdi, .tapShifting, .tapTdo,
    .adcConvStart, .ioRstN, .cpuRstN, .fetchVector, .adcPowerOn, .adcExtConv, .acPowerOn,
    .refPowerOn, .bodPowerOn, .wdtRunOn, .mainClkOn, .inputBufEn, .scanPortOn, .tdoOut, .tdoOeN);

  rsp_far_side u_far (.porLow, .pinLow, .bodLow, .tdoOut, .tdoOeN, .supplyAbovePot, .resetPinN,
    .bodBelowThr, .tdoWire);
  ////////////////////////////////////////////////////////////
  function automatic int tout(input logic [1:0] s, input logic [3:0] c);
    return (UNIT * (int'(s) + 1)) << c[1:0];
  endfunction : tout

  function automatic logic [19:0] pexp(input logic [2:0] m, input logic [2:0] b, input logic dbg,
                                      input logic [15:0] di);
    logic deep;
    deep = (m != 3'h0) && (m != 3'h1);
    return {~deep & ~b[1], b[0], b[0] | (~b[1] & b[2]),
      ~deep | (m == 3'h6) | (dbg & (m == 3'h2 | m == 3'h3)), ~di & (deep ? 16'h0001 : 16'hFFFF)};
  endfunction : pexp

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // one word, waits on ready both phases; read data kept in rd
  // a bus that never answers is left to the global cycle ceiling
  task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : ahb

  task automatic wait_run(output int n);
    n = 0;
    while (cpuRstN !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_run

  task automatic hit(input int s, input int k, input logic exR, input logic [4:0] fl);
    int n;
    @(posedge clk);
    pinLow <= (s == 0);
    wdtTimeout <= (s == 1);
    bodLow <= (s == 2);
    scanRstShift <= (s == 3);
    scanTdi <= 1'b1;
    repeat (k) @(posedge clk);
    pinLow <= 1'b0;
    wdtTimeout <= 1'b0;
    bodLow <= 1'b0;
    scanTdi <= 1'b0;
    @(negedge clk);
    check(ioRstN, !exR);
    @(posedge clk);
    scanRstShift <= 1'b0;
    wait_run(n);
    check(n < 300, 1);
    ahb(1'b0, `RSP_OFS_FLAGS, 0);
    check(rd, fl);
    ahb(1'b1, `RSP_OFS_FLAGS, 0);
  endtask : hit
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    int n, t;
    logic [2:0] b;
    logic [15:0] di;
    logic [19:0] e;
    void'($urandom(24));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      startupTimeFuses <= 2'($urandom);
      clockSelectFuses <= 4'($urandom);
      porLow <= 1'b1;
      @(negedge clk);
      check(ioRstN, 0);
      t = tout(startupTimeFuses, clockSelectFuses);
      @(posedge clk);
      porLow <= 1'b0;
      wait_run(n);
      check(n >= t + 1 && n <= t + 4, 1);
      check(fetchVector, 1);
      ahb(1'b0, `RSP_OFS_FLAGS, 0);
      check(rd, 1);
      ahb(1'b1, `RSP_OFS_FLAGS, 0);
    end
    $display("power-on test done");
    for (int i = 0; i < 7; i++) begin
      wdtEnable <= (i == 3);
      brownoutLevelFuses <= (i == 5) ? 3'h5 : 3'h7;
      scanPortEnableFuse <= (i == 6);
      hit(SRC[i], LEN[i], FLG[i] != 5'h00, FLG[i]);
    end
    $display("source test done");
    @(posedge clk);
    tapShifting <= 1'b1;
    tapTdo <= 1'($urandom);
    repeat (2) @(negedge clk);
    check({scanPortOn, tdoOeN, tdoWire}, {2'b10, tapTdo});
    @(posedge clk);
    tapShifting <= 1'b0;
    repeat (2) @(negedge clk);
    check({tdoOeN, tdoWire}, 2'b11);
    ahb(1'b1, `RSP_OFS_CTRL, 1);
    hit(3, 2, 1'b0, 5'h00);
    check(scanPortOn, 0);
    ahb(1'b1, `RSP_OFS_CTRL, 0);
    ahb(1'b0, 5'h1C, 0);
    check(rd, 0);
    $display("scan test done");
    for (int i = 0; i < 5; i++) begin
      b = 3'($urandom);
      di = 16'($urandom);
      debugEnableFuse <= 1'($urandom);
      scanPortEnableFuse <= 1'($urandom);
      ahb(1'b1, `RSP_OFS_PWR, {MODES[i], 1'b0, b});
      ahb(1'b1, `RSP_OFS_DIGITAL_INPUT_DISABLE_0, di[7:0]);
      ahb(1'b1, `RSP_OFS_DIGITAL_INPUT_DISABLE_1, di[15:8]);
      sleepActive <= 1'b1;
      repeat (3) @(negedge clk);
      e = pexp(MODES[i], b, debugEnableFuse & scanPortEnableFuse, di);
      check({acPowerOn, adcPowerOn, refPowerOn, mainClkOn, inputBufEn}, e);
      check(inputBufEn, e[15:0]);
      @(posedge clk);
      sleepActive <= 1'b0;
    end
    $display("sleep test done");
    ahb(1'b1, `RSP_OFS_PWR, 0);
    ahb(1'b1, `RSP_OFS_PWR, 1);
    repeat (2) @(negedge clk);
    check(adcExtConv, 1);
    @(posedge clk);
    adcConvStart <= 1'b1;
    @(posedge clk);
    adcConvStart <= 1'b0;
    repeat (2) @(negedge clk);
    check(adcExtConv, 0);
    $display("converter test done");
    tally_and_finish();
  end
endmodule : rsp_reset_sleep_tb
